// ---- common/pdcs_regs.svh ----
`ifndef PDCS_REGS_SVH
`define PDCS_REGS_SVH

// register word indices, matched against paddr[9:2] (0xaa is not a multiple of four: printed offsets are indices)
`define PDCS_IDX_CTRL 8'ha8
`define PDCS_IDX_STAT 8'haa
`define PDCS_IDX_IRQ_STAT 8'hb8
`define PDCS_IDX_IRQ_EN 8'hb9
`define PDCS_IDX_IRQ_CLR 8'hba
`define PDCS_IDX_STRAP 8'hbb

// control field positions
`define PDCS_CTRL_COR_EN 0
`define PDCS_CTRL_NONFATAL_EN 1
`define PDCS_CTRL_FATAL_EN 2
`define PDCS_CTRL_UR_EN 3
`define PDCS_CTRL_RELAX_ORD 4
`define PDCS_CTRL_PAYLOAD_LO 5
`define PDCS_CTRL_PAYLOAD_HI 7
`define PDCS_CTRL_EXT_TAG 8
`define PDCS_CTRL_PHANTOM 9
`define PDCS_CTRL_AUX_PM 10
`define PDCS_CTRL_NO_SNOOP 11
`define PDCS_CTRL_RDREQ_LO 12
`define PDCS_CTRL_RDREQ_HI 14
`define PDCS_CTRL_FLR 15

// status field positions
`define PDCS_STAT_COR 0
`define PDCS_STAT_NONFATAL 1
`define PDCS_STAT_FATAL 2
`define PDCS_STAT_UR 3
`define PDCS_STAT_AUX_PWR 4
`define PDCS_STAT_PENDING 5
`define PDCS_STAT_W1C_MASK 16'h000f

// reset values and the largest supported payload code
`define PDCS_RST_RELAX_ORD 1'b1
`define PDCS_RST_NO_SNOOP 1'b1
`define PDCS_RST_PAYLOAD 3'h0
`define PDCS_RST_RDREQ 3'h2
`define PDCS_MAX_PAYLOAD 3'h0

`endif

// ---- common/pdcs_pkg.sv ----
`default_nettype none
package pdcs_pkg;
  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pdcs_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pdcs_apb_rsp_s;

  // error events from the transaction logic, one-cycle pulses
  typedef struct packed {
    logic ur;
    logic fatal;
    logic nonfatal;
    logic cor;
  } pdcs_err_s;

  typedef struct packed {
    logic ur_report_en;
    logic fatal_report_en;
    logic nonfatal_report_en;
    logic cor_report_en;
    logic relaxed_order_en;
    logic no_snoop_en;
    logic aux_pm_en;
    logic [2:0] max_payload;
    logic [2:0] max_read_req;
  } pdcs_ctrl_s;

  typedef enum logic [1:0] {PDCS_IDLE, PDCS_ACCESS} pdcs_phase_e;
endpackage
`default_nettype wire

// ---- logic/pdcs_sticky_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pdcs_regs.svh"

// sticky event flags: set wins over write-one clear
module pdcs_sticky_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] set_in,
  input wire logic [3:0] clr_in,
  output logic [3:0] flags
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 4'h0;
    end else begin
      flags <= set_in | (flags & ~clr_in);
    end
  end
endmodule
`default_nettype wire

// ---- logic/pdcs_dev_regs.sv ----
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pdcs_regs.svh"

module pdcs_dev_regs
  import pdcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic aux_power_rst_n,
  input wire pdcs_pkg::pdcs_apb_req_s apb_req,
  output pdcs_pkg::pdcs_apb_rsp_s apb_rsp,
  input wire pdcs_pkg::pdcs_err_s err_event,
  input wire logic aux_power_detect_strap,
  input wire logic np_pending,
  output pdcs_pkg::pdcs_ctrl_s ctrl,
  output pdcs_pkg::pdcs_err_s err_msg_send,
  output logic flr_start,
  output logic irq
);
  import pdcs_pkg::*;

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic is_hit(input logic [7:0] index, input logic [7:0] target);
    is_hit = index == target;
  endfunction

  // payload codes above the supported size fall back to the largest supported one
  function automatic logic [2:0] clamp_payload(input logic [2:0] code);
    clamp_payload = (code > `PDCS_MAX_PAYLOAD) ? `PDCS_MAX_PAYLOAD : code;
  endfunction

  function automatic logic [5:0] set_wins(input logic [5:0] set_bits, input logic [5:0] cur, input logic [5:0] clr);
    set_wins = set_bits | (cur & ~clr);
  endfunction

  pdcs_phase_e phase;
  logic [4:0] ctrl_lo;
  logic [2:0] ctrl_payload;
  logic [3:0] ctrl_hi;
  logic rsp_ready;
  logic rsp_err;
  logic [31:0] rsp_data;
  pdcs_ctrl_s next_ctrl;
  logic aux_pm;
  logic [3:0] err_flags;
  logic aux_det;
  logic aux_meta;
  logic aux_sync;
  logic pend_meta;
  logic pend_sync;
  logic [5:0] irq_stat;
  logic [5:0] irq_en;
  logic strap_taken;
  wire logic [15:0] ctrl_reg = {1'b0, ctrl_hi, 3'h0, ctrl_payload, ctrl_lo};

  wire logic [7:0] idx = word_index(apb_req.paddr);
  wire logic setup = apb_req.psel && !apb_req.penable && phase == PDCS_IDLE;
  wire logic commit = apb_req.psel && apb_req.penable && phase == PDCS_ACCESS;
  wire logic wr = commit && apb_req.pwrite;

  // register decode
  wire logic hit_ctrl = is_hit(idx, `PDCS_IDX_CTRL);
  wire logic hit_stat = is_hit(idx, `PDCS_IDX_STAT);
  wire logic hit_istat = is_hit(idx, `PDCS_IDX_IRQ_STAT);
  wire logic hit_ien = is_hit(idx, `PDCS_IDX_IRQ_EN);
  wire logic hit_iclr = is_hit(idx, `PDCS_IDX_IRQ_CLR);
  wire logic hit_strap = is_hit(idx, `PDCS_IDX_STRAP);
  wire logic mapped = hit_ctrl | hit_stat | hit_istat | hit_ien | hit_iclr | hit_strap;
  wire logic wr_ctrl = wr && hit_ctrl;
  wire logic [15:0] wd = apb_req.pwdata[15:0];
  wire logic [2:0] payload_wr = clamp_payload(wd[`PDCS_CTRL_PAYLOAD_HI:`PDCS_CTRL_PAYLOAD_LO]);

  wire logic stat_wr = wr && hit_stat;
  wire logic [15:0] stat_w1c_bits = wd & `PDCS_STAT_W1C_MASK;
  wire logic [3:0] stat_clr = stat_wr ? stat_w1c_bits[3:0] : 4'h0;
  wire logic [15:0] stat_word = {10'h000, pend_sync, aux_det, err_flags};
  wire logic [15:0] ctrl_word = {1'b0, ctrl_reg[14:11], aux_pm, 2'b00, ctrl_reg[7:0]};
  wire logic [5:0] ev = {pend_sync, aux_det, err_event.ur, err_event.fatal, err_event.nonfatal, err_event.cor};
  wire logic iclr_wr = wr && hit_iclr;
  wire logic ien_wr = wr && hit_ien;
  wire logic [5:0] irq_clr = iclr_wr ? wd[5:0] : 6'h00;
  wire logic [5:0] next_irq_stat = set_wins(ev, irq_stat, irq_clr);
  wire logic [5:0] irq_hot = irq_stat & irq_en;
  wire logic next_irq = |irq_hot;

  // read word of each register
  wire logic [31:0] ctrl_rd = {16'h0000, ctrl_word};
  wire logic [31:0] stat_rd = {16'h0000, stat_word};
  wire logic [31:0] istat_rd = {26'h0, irq_stat};
  wire logic [31:0] ien_rd = {26'h0, irq_en};
  wire logic [31:0] strap_rd = {31'h0, aux_det};
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd :
    hit_stat ? stat_rd :
    hit_istat ? istat_rd :
    hit_ien ? ien_rd :
    hit_strap ? strap_rd : 32'h0;

  wire logic rd_setup = setup && !apb_req.pwrite;
  wire logic [31:0] next_prdata = rd_setup ? rd_mux : 32'h0;
  wire logic next_pslverr = setup && !mapped;
  wire logic [3:0] next_err_msg = err_event & ctrl_reg[3:0];
  wire logic [4:0] ctrl_wr_lo = wd[4:0];
  wire logic [3:0] ctrl_wr_hi = wd[14:11];

  // registered control levels handed to the transaction logic
  assign next_ctrl.cor_report_en = ctrl_reg[`PDCS_CTRL_COR_EN];
  assign next_ctrl.nonfatal_report_en = ctrl_reg[`PDCS_CTRL_NONFATAL_EN];
  assign next_ctrl.fatal_report_en = ctrl_reg[`PDCS_CTRL_FATAL_EN];
  assign next_ctrl.ur_report_en = ctrl_reg[`PDCS_CTRL_UR_EN];
  assign next_ctrl.relaxed_order_en = ctrl_reg[`PDCS_CTRL_RELAX_ORD];
  assign next_ctrl.no_snoop_en = ctrl_reg[`PDCS_CTRL_NO_SNOOP];
  assign next_ctrl.aux_pm_en = aux_pm;
  assign next_ctrl.max_payload = ctrl_reg[`PDCS_CTRL_PAYLOAD_HI:`PDCS_CTRL_PAYLOAD_LO];
  assign next_ctrl.max_read_req = ctrl_reg[`PDCS_CTRL_RDREQ_HI:`PDCS_CTRL_RDREQ_LO];

  assign apb_rsp.prdata = rsp_data;
  assign apb_rsp.pready = rsp_ready;
  assign apb_rsp.pslverr = rsp_err;

  // bus phase tracker: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PDCS_IDLE;
    end else begin
      phase <= setup ? PDCS_ACCESS : PDCS_IDLE;
    end
  end

  // access response: one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_ready <= 1'b0;
    end else begin
      rsp_ready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_err <= 1'b0;
    end else begin
      rsp_err <= next_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_data <= 32'h0;
    end else begin
      rsp_data <= next_prdata;
    end
  end

  // control bits; bit 10 lives on the aux power reset only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_lo <= {`PDCS_RST_RELAX_ORD, 4'h0};
    end else if (wr_ctrl) begin
      ctrl_lo <= ctrl_wr_lo;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_payload <= `PDCS_RST_PAYLOAD;
    end else if (wr_ctrl) begin
      ctrl_payload <= payload_wr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_hi <= {`PDCS_RST_RDREQ, `PDCS_RST_NO_SNOOP};
    end else if (wr_ctrl) begin
      ctrl_hi <= ctrl_wr_hi;
    end
  end

  always_ff @(posedge pclk or negedge aux_power_rst_n) begin
    if (!aux_power_rst_n) begin
      aux_pm <= 1'b0;
    end else if (wr_ctrl) begin
      aux_pm <= wd[`PDCS_CTRL_AUX_PM];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flr_start <= 1'b0;
    end else begin
      flr_start <= wr_ctrl && wd[`PDCS_CTRL_FLR];
    end
  end

  pdcs_sticky_flags u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(err_event),
    .clr_in(stat_clr),
    .flags(err_flags)
  );

  // strap and pending levels pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_meta <= 1'b0;
      aux_sync <= 1'b0;
    end else begin
      aux_meta <= aux_power_detect_strap;
      aux_sync <= aux_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_meta <= 1'b0;
      pend_sync <= 1'b0;
    end else begin
      pend_meta <= np_pending;
      pend_sync <= pend_meta;
    end
  end

  // aux_det loads aux_sync (still at its reset 0) on the first edge after reset, then only rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_det <= 1'b0;
    end else if (!strap_taken || aux_sync) begin
      aux_det <= aux_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // error message gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_msg_send <= '0;
    end else begin
      err_msg_send <= next_err_msg;
    end
  end

  // interrupt status: sticky, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 6'h00;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= 6'h00;
    end else if (ien_wr) begin
      irq_en <= wd[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

// ---- tb/pdcs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdcs_host_model
  import pdcs_pkg::*;
(
  input wire logic pclk,
  output pdcs_pkg::pdcs_apb_req_s req,
  input wire pdcs_pkg::pdcs_apb_rsp_s rsp
);
  initial req = '0;
  // one transfer, held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/pdcs_dev_regs_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdcs_dev_regs_chk
  import pdcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pdcs_pkg::pdcs_apb_req_s apb_req,
  input wire pdcs_pkg::pdcs_apb_rsp_s apb_rsp,
  input wire pdcs_pkg::pdcs_err_s err_event,
  input wire pdcs_pkg::pdcs_ctrl_s ctrl,
  input wire pdcs_pkg::pdcs_err_s err_msg_send,
  input wire logic flr_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic done = apb_req.psel && apb_req.penable && apb_rsp.pready;
  wire logic wr_c = done && apb_req.pwrite && apb_req.paddr == 32'h2a0;
  wire logic setup = apb_req.psel && !apb_req.penable;
  wire logic [4:0] en = {ctrl.relaxed_order_en, ctrl.ur_report_en, ctrl.fatal_report_en, ctrl.nonfatal_report_en,
    ctrl.cor_report_en};
  property p_msg;
    err_msg_send == ($past(err_event) & $past(en[3:0]));
  endproperty
  a_msg: assert property (p_msg) else $error("error message mismatch");
  property p_flr;
    flr_start == $past(wr_c && apb_req.pwdata[15]);
  endproperty
  a_flr: assert property (p_flr) else $error("function reset pulse mismatch");
  property p_pay;
    ctrl.max_payload == 3'h0;
  endproperty
  a_pay: assert property (p_pay) else $error("payload size too large");
  property p_rdy;
    setup |=> apb_rsp.pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_unm;
    setup && apb_req.paddr == 32'h100 |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not refused");
  property p_crd;
    done && !apb_req.pwrite && apb_req.paddr == 32'h2a0 |-> apb_rsp.prdata[15:0] == {1'b0, ctrl.max_read_req,
      ctrl.no_snoop_en, ctrl.aux_pm_en, 2'b00, ctrl.max_payload, en};
  endproperty
  a_crd: assert property (p_crd) else $error("control read mismatch");
  property p_srd;
    done && !apb_req.pwrite && apb_req.paddr == 32'h2a8 |-> apb_rsp.prdata[15:6] == 10'h0;
  endproperty
  a_srd: assert property (p_srd) else $error("status reserved bits set");
  property p_wr;
    wr_c |-> ##2 {ctrl.max_read_req, ctrl.no_snoop_en, ctrl.aux_pm_en, en} == $past({apb_req.pwdata[14:10],
      apb_req.pwdata[4:0]}, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("control write not taken");
endmodule
`default_nettype wire

// ---- tb/pcie_device_ctrl_status_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pdcs_regs.svh"
module pcie_device_ctrl_status_regs_tb_top;
  import pdcs_pkg::*;
  logic pclk, presetn, aux_rst_n, strap, pend, flr, irq, e;
  pdcs_apb_req_s req;
  pdcs_apb_rsp_s rsp;
  pdcs_err_s ev, msg;
  pdcs_ctrl_s ctrl;
  logic [31:0] q;
  int n_mismatch = 0, check_count = 0;
  logic [39:0] rows [5] = '{{8'ha8, 16'hffff, 16'h7c1f}, {8'ha8, 16'h5a35, 16'h5815}, {8'ha8, 16'h0, 16'h0},
    {8'haa, 16'hffc0, 16'h0010}, {8'hb9, 16'h000f, 16'h000f}};
  pdcs_dev_regs dut_u (.pclk(pclk), .presetn(presetn), .aux_power_rst_n(aux_rst_n), .apb_req(req), .apb_rsp(rsp),
    .err_event(ev), .aux_power_detect_strap(strap), .np_pending(pend), .ctrl(ctrl), .err_msg_send(msg),
    .flr_start(flr), .irq(irq));
  pdcs_host_model host_u (.pclk(pclk), .req(req), .rsp(rsp));
  task automatic acc(input logic w, input logic [7:0] i, input logic [15:0] d);
    host_u.xfer(w, {22'h0, i, 2'b00}, {16'h0, d}, q, e);
  endtask
  task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {presetn, aux_rst_n, strap, pend, ev} = 8'h20;
    repeat (10) @(posedge pclk);
    {presetn, aux_rst_n} <= 2'b11;
    acc(0, `PDCS_IDX_CTRL, 0);
    chk("ctrl reset", 16'h2810, q[15:0]);
    foreach (rows[k]) begin
      acc(1, rows[k][39:32], rows[k][31:16]);
      acc(0, rows[k][39:32], 0);
      chk("row", rows[k][15:0], q[15:0]);
    end
    acc(1, `PDCS_IDX_CTRL, 16'h000f);
    @(posedge pclk) ev <= '1;
    @(posedge pclk) ev <= '0;
    @(negedge pclk) chk("err msg", 16'hf, {12'h0, msg});
    acc(0, `PDCS_IDX_STAT, 0);
    chk("stat err", 16'h001f, q[15:0]);
    acc(1, `PDCS_IDX_STAT, 16'h0005);
    acc(0, `PDCS_IDX_STAT, 0);
    chk("stat w1c", 16'h001a, q[15:0]);
    chk("irq on", 16'h1, {15'h0, irq});
    acc(1, `PDCS_IDX_IRQ_EN, 0);
    repeat (3) @(negedge pclk);
    chk("irq masked", 16'h0, {15'h0, irq});
    acc(1, `PDCS_IDX_IRQ_EN, 16'hf);
    acc(1, `PDCS_IDX_IRQ_CLR, 16'hf);
    repeat (3) @(negedge pclk);
    chk("irq cleared", 16'h0, {15'h0, irq});
    acc(0, 8'h40, 0);
    chk("unmapped", 16'h1, {15'h0, e});
    pend <= 1'b1;
    repeat (4) @(posedge pclk);
    acc(0, `PDCS_IDX_STAT, 0);
    chk("pending", 16'h003a, q[15:0]);
    pend <= 1'b0;
    acc(1, `PDCS_IDX_CTRL, 16'h0400);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    acc(0, `PDCS_IDX_CTRL, 0);
    chk("sticky", 16'h2c10, q[15:0]);
    acc(0, `PDCS_IDX_STAT, 0);
    chk("stat reset", 16'h0010, q[15:0]);
    acc(1, `PDCS_IDX_CTRL, 16'h8000);
    @(negedge pclk) chk("flr", 16'h1, {15'h0, flr});
    end_of_test();
  end
endmodule
bind pdcs_dev_regs pdcs_dev_regs_chk chk_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .err_event(err_event), .ctrl(ctrl), .err_msg_send(err_msg_send), .flr_start(flr_start));
`default_nettype wire
